//--- logic/rlr_cfg.svh
// Constants for the return-with-literal and rotate-through-carry unit.
`ifndef RLR_CFG_SVH
`define RLR_CFG_SVH
`define RLR_DATA_W 8
`define RLR_ADDR_W 7
`define RLR_PC_W 15
`define RLR_RET_CYCLES 2'd2
`define RLR_DEST_W 1'b0
`define RLR_DEST_F 1'b1
`define RLR_MSB 7
`define RLR_LSB 0
`endif

//--- logic/rlr_exec.sv
// Execution unit for return-with-literal and rotate-through-carry.
// Notes on behaviour
// - Return-with-literal loads its 8-bit literal into the working register.
// - Return-with-literal pops the return stack and loads PC from its top.
// - Return-with-literal takes two cycles and leaves status flags alone.
// - Rotate left: carry into bit 0, old bit 7 becomes carry.
// - Rotate left writes to working register on 0, source on 1.
// - Rotate right: carry into bit 7, old bit 0 becomes carry.
// - Rotate right writes to working register on 0, source on 1.
`timescale 1ns/100ps
`include "rlr_cfg.svh"
module rlr_exec
    import rlr_pkg::*;
#(
    parameter int PC_W = `RLR_PC_W
)(
    input wire logic clk_i,                       // Instruction clock
    input wire logic rst_n_i,                     // Async reset, active low
    input wire logic ce_i,                        // Clock enable
    input wire logic issue_i,                     // Instruction offered
    input wire rlr_instr_t instr_i,               // Decoded instruction
    input wire logic [`RLR_DATA_W-1:0] fdata_i,   // Addressed file register
    input wire logic carry_i,                     // Current carry flag
    input wire logic [PC_W-1:0] top_of_return_stack_i, // Stack top
    output logic busy_o,                          // Second return cycle
    output logic done_o,                          // Instruction completes
    output logic [`RLR_ADDR_W-1:0] faddr_o,       // File register address
    output logic [`RLR_DATA_W-1:0] w_o,           // Working register data
    output logic w_we_o,                          // Working register write
    output logic [`RLR_DATA_W-1:0] f_o,           // File register data
    output logic f_we_o,                          // File register write
    output logic carry_o,                         // New carry value
    output logic carry_we_o,                      // Carry write
    output logic stack_pop_o,                     // Pop return stack
    output logic [PC_W-1:0] pc_o,                 // New program counter
    output logic pc_we_o                          // Program counter load
);
    typedef enum logic {
        RLR_ST_IDLE,
        RLR_ST_RET2
    } rlr_state_t;

    rlr_state_t state_r, state_nxt;
    rlr_rot_t rot;
    logic accept;
    logic [`RLR_DATA_W-1:0] w_r, w_nxt, f_r, f_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic w_we_r, w_we_nxt, f_we_r, f_we_nxt;
    logic c_r, c_nxt, c_we_r, c_we_nxt;
    logic pop_r, pop_nxt, pcwe_r, pcwe_nxt, done_r, done_nxt;

    rlr_rotator i_rlr_rotator (
        .data_i(fdata_i),
        .carry_i(carry_i),
        .left_i(instr_i.op == RLR_OP_ROT_LEFT),
        .result_o(rot)
    );

    ////////////////////////////////////////////////////////////////////////
    // A return occupies the unit for a second cycle; new issues are ignored
    // then, so the sequencer must hold off while busy_o is high.
    assign busy_o = (state_r == RLR_ST_RET2);
    assign accept = issue_i && !busy_o;
    assign faddr_o = instr_i.faddr;

    always_comb begin
        state_nxt = state_r;
        w_nxt = w_r;
        f_nxt = f_r;
        pc_nxt = pc_r;
        c_nxt = c_r;
        w_we_nxt = 1'b0;
        f_we_nxt = 1'b0;
        c_we_nxt = 1'b0;
        pop_nxt = 1'b0;
        pcwe_nxt = 1'b0;
        done_nxt = 1'b0;
        case (state_r)
            RLR_ST_IDLE: begin
                if (accept) begin
                    case (instr_i.op)
                        RLR_OP_RET_LIT: begin
                            w_nxt = instr_i.literal;
                            pc_nxt = top_of_return_stack_i;
                            state_nxt = RLR_ST_RET2;
                        end
                        RLR_OP_ROT_LEFT, RLR_OP_ROT_RIGHT: begin
                            c_nxt = rot.carry;
                            c_we_nxt = 1'b1;
                            done_nxt = 1'b1;
                            if (instr_i.dest == `RLR_DEST_W) begin
                                w_nxt = rot.data;
                                w_we_nxt = 1'b1;
                            end else begin
                                f_nxt = rot.data;
                                f_we_nxt = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            RLR_ST_RET2: begin
                // Results commit at the end of the second cycle; no flags.
                w_we_nxt = 1'b1;
                pop_nxt = 1'b1;
                pcwe_nxt = 1'b1;
                done_nxt = 1'b1;
                state_nxt = RLR_ST_IDLE;
            end
            default: state_nxt = RLR_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= RLR_ST_IDLE;
            w_r <= '0;
            f_r <= '0;
            pc_r <= '0;
            c_r <= 1'b0;
            w_we_r <= 1'b0;
            f_we_r <= 1'b0;
            c_we_r <= 1'b0;
            pop_r <= 1'b0;
            pcwe_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            w_r <= w_nxt;
            f_r <= f_nxt;
            pc_r <= pc_nxt;
            c_r <= c_nxt;
            w_we_r <= w_we_nxt;
            f_we_r <= f_we_nxt;
            c_we_r <= c_we_nxt;
            pop_r <= pop_nxt;
            pcwe_r <= pcwe_nxt;
            done_r <= done_nxt;
        end
    end

    assign w_o = w_r;
    assign w_we_o = w_we_r;
    assign f_o = f_r;
    assign f_we_o = f_we_r;
    assign carry_o = c_r;
    assign carry_we_o = c_we_r;
    assign stack_pop_o = pop_r;
    assign pc_o = pc_r;
    assign pc_we_o = pcwe_r;
    assign done_o = done_r;

    ////////////////////////////////////////////////////////////////////////
    // Cycle counts below are in enabled edges; a low clock enable stretches
    // an instruction but must not change what it does.
    ret_literal_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accept && instr_i.op == RLR_OP_RET_LIT ##1 ce_i [*1]
        |=> w_we_o && w_o == $past(instr_i.literal, 2))
        else $error("literal not delivered to working register");
    ret_pop_pc_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accept && instr_i.op == RLR_OP_RET_LIT ##1 ce_i
        |=> stack_pop_o && pc_we_o
            && pc_o == $past(top_of_return_stack_i, 2))
        else $error("return did not pop stack into program counter");
    ret_two_cycle_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accept && instr_i.op == RLR_OP_RET_LIT
        |=> busy_o && !done_o && !carry_we_o)
        else $error("return finished early or touched carry");
    ret_no_flag_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        pc_we_o |-> !carry_we_o && !f_we_o)
        else $error("return changed a flag or file register");
    ret_wait_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        busy_o |-> !w_we_o && !pc_we_o && !stack_pop_o && !done_o)
        else $error("return committed in its first cycle");
    busy_refuse_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && busy_o |=> !busy_o && done_o && !carry_we_o && !f_we_o)
        else $error("issue taken while busy or return stretched");
    ce_hold_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !ce_i |=> $stable(busy_o) && $stable(done_o) && $stable(w_o)
            && $stable(f_o) && $stable(pc_o) && $stable(carry_o))
        else $error("state moved while clock enable was low");
    rot_left_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accept && instr_i.op == RLR_OP_ROT_LEFT
        |=> carry_o == $past(fdata_i[`RLR_MSB]) && (w_we_o ? w_o : f_o)
            == {$past(fdata_i[`RLR_MSB-1:`RLR_LSB]), $past(carry_i)})
        else $error("rotate left result wrong");
    rot_left_dest_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accept && instr_i.op == RLR_OP_ROT_LEFT
        |=> f_we_o == $past(instr_i.dest) && w_we_o != f_we_o)
        else $error("rotate left destination wrong");
    rot_right_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accept && instr_i.op == RLR_OP_ROT_RIGHT
        |=> carry_o == $past(fdata_i[`RLR_LSB]) && (w_we_o ? w_o : f_o)
            == {$past(carry_i), $past(fdata_i[`RLR_MSB:`RLR_LSB+1])})
        else $error("rotate right result wrong");
    rot_right_dest_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accept && instr_i.op == RLR_OP_ROT_RIGHT
        |=> f_we_o == $past(instr_i.dest) && w_we_o != f_we_o)
        else $error("rotate right destination wrong");
    rot_single_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accept
        && instr_i.op inside {RLR_OP_ROT_LEFT, RLR_OP_ROT_RIGHT}
        |=> done_o && carry_we_o && !busy_o && !pc_we_o && !stack_pop_o)
        else $error("rotate not single cycle");
    rot_keep_pc_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        carry_we_o |-> !pc_we_o && !stack_pop_o && !busy_o)
        else $error("rotate touched the program counter");
    op_none_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accept && instr_i.op == RLR_OP_NONE
        |=> !done_o && !busy_o && !carry_we_o && !w_we_o && !f_we_o)
        else $error("empty issue produced a result");
endmodule

//--- logic/rlr_pkg.sv
// Types shared by the return-with-literal and rotate-through-carry unit.
`include "rlr_cfg.svh"
package rlr_pkg;
    typedef enum logic [1:0] {
        RLR_OP_NONE,
        RLR_OP_RET_LIT,
        RLR_OP_ROT_LEFT,
        RLR_OP_ROT_RIGHT
    } rlr_op_t;

    typedef struct packed {
        rlr_op_t op;
        logic [`RLR_DATA_W-1:0] literal;
        logic [`RLR_ADDR_W-1:0] faddr;
        logic dest;
    } rlr_instr_t;

    typedef struct packed {
        logic [`RLR_DATA_W-1:0] data;
        logic carry;
    } rlr_rot_t;
endpackage

//--- logic/rlr_rotator.sv
// Rotate-through-carry datapath, one position left or right.
`timescale 1ns/100ps
`include "rlr_cfg.svh"
module rlr_rotator
    import rlr_pkg::*;
(
    input wire logic [`RLR_DATA_W-1:0] data_i, // Source register value
    input wire logic carry_i,                  // Carry before the rotate
    input wire logic left_i,                   // High rotates left
    output rlr_rot_t result_o                  // Rotated data and new carry
);
    always_comb begin
        if (left_i) begin
            result_o.data = {data_i[`RLR_MSB-1:`RLR_LSB],
                             carry_i};
            result_o.carry = data_i[`RLR_MSB];
        end else begin
            result_o.data = {carry_i,
                             data_i[`RLR_MSB:`RLR_LSB+1]};
            result_o.carry = data_i[`RLR_LSB];
        end
    end
endmodule

//--- test/rlr_exec_bench.sv
// Self-checking bench for the return-with-literal and rotate unit.
`timescale 1ns/100ps
`include "rlr_cfg.svh"
module return_literal_rotate_exec_bench;
    import rlr_pkg::*;
    localparam int PC_W = 15;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic issue_i = 1'b0;
    rlr_instr_t instr_i = '0;
    logic [7:0] fdata_i = 8'h00;
    logic carry_i = 1'b0;
    logic [PC_W-1:0] stack_top_i = '0;
    logic busy_o, done_o, w_we_o, f_we_o, carry_o, carry_we_o;
    logic stack_pop_o, pc_we_o;
    logic [6:0] faddr_o;
    logic [7:0] w_o, f_o;
    logic [PC_W-1:0] pc_o;
    wire [6:0] flags = {busy_o, done_o, w_we_o, f_we_o, carry_we_o,
                        stack_pop_o, pc_we_o};
    int failures = 0;
    int tests_run = 0;
    int seed = 37;
    int model_q[$];

    rlr_exec #(.PC_W(PC_W)) i_rlr_exec (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ce_i(ce_i), .issue_i(issue_i), .instr_i(instr_i),
        .fdata_i(fdata_i), .carry_i(carry_i),
        .top_of_return_stack_i(stack_top_i), .busy_o(busy_o),
        .done_o(done_o),
        .faddr_o(faddr_o), .w_o(w_o), .w_we_o(w_we_o), .f_o(f_o),
        .f_we_o(f_we_o), .carry_o(carry_o), .carry_we_o(carry_we_o),
        .stack_pop_o(stack_pop_o), .pc_o(pc_o), .pc_we_o(pc_we_o));

    always #2 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time,
                     what, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("counts: %0d compared, %0d mismatched", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Integer model: the carry is treated as a ninth bit of the value.
    task automatic rot(input rlr_op_t op, input logic [7:0] d,
                       input logic c, input logic dst);
        int v;
        int r;
        int nc;
        ce_i = 1'b1;
        issue_i = 1'b1;
        instr_i = '{op, 8'($random(seed)), 7'($random(seed)), dst};
        fdata_i = d;
        carry_i = c;
        if (op == RLR_OP_ROT_LEFT) begin
            v = d * 2 + c;
            r = v % 256;
            nc = v / 256;
        end else begin
            v = c * 256 + d;
            r = v / 2;
            nc = v % 2;
        end
        model_q.push_back(nc);
        model_q.push_back(r);
        #1 chk(faddr_o, instr_i.faddr, "address");
        @(negedge clk_i);
        chk(flags, {1'b0, 1'b1, ~dst, dst, 3'b100},
            "rotate strobes");
        chk(carry_o, model_q.pop_front(), "carry");
        chk(dst ? f_o : w_o, model_q.pop_front(),
            "rotate result");
    endtask

    // A rotate offered while busy must be ignored, and the stack top is
    // changed so that a late sample of it shows up in the new PC.
    task automatic ret(input logic [7:0] lit,
                       input logic [PC_W-1:0] ret_addr);
        ce_i = 1'b1;
        issue_i = 1'b1;
        instr_i = '{RLR_OP_RET_LIT, lit, 7'($random(seed)), 1'($random(seed))};
        stack_top_i = ret_addr;
        carry_i = 1'($random(seed));
        @(negedge clk_i);
        chk(flags, 7'b1000000, "return first cycle");
        instr_i.op = RLR_OP_ROT_RIGHT;
        stack_top_i = ~ret_addr;
        @(negedge clk_i);
        chk(flags, 7'b0110011, "return strobes");
        chk(w_o, lit, "literal");
        chk(pc_o, ret_addr, "return address");
    endtask

    task automatic nop(input logic ce);
        ce_i = ce;
        issue_i = 1'b1;
        instr_i.op = ce ? RLR_OP_NONE : RLR_OP_ROT_LEFT;
        @(negedge clk_i);
        chk(flags, 7'h00, "idle");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        chk(flags, 7'h00, "reset");
        rot(RLR_OP_ROT_LEFT, 8'he6, 1'b0, 1'b0);
        for (int i = 0; i < 16; i++) begin
            rot(i[0] ? RLR_OP_ROT_LEFT : RLR_OP_ROT_RIGHT,
                i[3] ? 8'hff : 8'h00, i[2], i[1]);
        end
        for (int i = 0; i < 200; i++) begin
            rot($random(seed) % 2 ? RLR_OP_ROT_LEFT : RLR_OP_ROT_RIGHT,
                8'($random(seed)), 1'($random(seed)), 1'($random(seed)));
        end
        // Strobes of a finished rotate must stand while the enable is low.
        rot(RLR_OP_ROT_RIGHT, 8'h01, 1'b1, 1'b1);
        ce_i = 1'b0;
        @(negedge clk_i);
        chk(flags, 7'b0101100, "frozen strobes");
        chk(f_o, 8'h80, "frozen result");
        $display("test rotates finished");
        nop(1'b1);
        nop(1'b0);
        nop(1'b0);
        nop(1'b1);
        $display("test idle and clock enable finished");
        ret(8'h00, '0);
        ret(8'hff, '1);
        for (int i = 0; i < 100; i++) begin
            if ($random(seed) % 3 == 0) begin
                ret(8'($random(seed)), PC_W'($random(seed)));
            end else begin
                rot($random(seed) % 2 ? RLR_OP_ROT_LEFT : RLR_OP_ROT_RIGHT,
                    8'($random(seed)), 1'($random(seed)), 1'($random(seed)));
            end
        end
        nop(1'b1);
        $display("test returns finished");
        test_done();
    end

    initial begin
        #200000;
        failures++;
        $display("mismatch at %0t: run did not finish", $time);
        test_done();
    end
endmodule
